// ===== scs_strap_config_select.sv
// Purpose: Strap capture and configuration method selection for a four-port hub.
// Assumes: Straps and the data line are synchronous to mclk_i; the board holds
//          strap levels through resistors only until the first clock edge after reset release.
// Notes:   Pins are released while reset stands and driven as outputs after capture.
// Contract
// RL1: Drive strap pins in normal operation; release them while any reset is active.
// RL2: Capture each strap level at reset release and use it as defaults.
// RL3: Board never drives strap pins; only resistors set their levels.
// RL4: Choose the configuration method from data line and two select bits.
// RL5: Select bits 00 give strap and OTP self-powered configuration.
// RL6: Select bits 10 give strap and OTP bus-powered configuration.
// RL7: Data high, select 11 loads EEPROM plus OTP, ignores straps.
// RL8: Data high, select 01 waits for SMBus host, ignores straps.
// RL9: Data low, select 01 is flagged invalid and proceeds nowhere.
// RL10: SMBus host ends the wait by writing register address 0xff.
// RL11: Fixed-port straps select non-removable ports: none, 1, 1-2, 1-3.
// RL12: Suspend indicator active high for codes 00 and 10, else active low.
// RL13: With local power detect, non-removable ports come from internal registers.
// RL14: A high charge-enable strap makes that port report charging support.
// RL15: Port disabled only when both line-disable straps are captured high.
// RL16: Vendor-specific USB messages are accepted by default.
// RL17: I2C operations from USB pass straight through uninterpreted.
// RL18: OTP access over USB works in single-ended mode only.
// RL19: OTP access over SMBus supports all four operating modes.
// RL20: SMBus configuration writes are accepted only before hub attach.
// RL21: USB host may change battery charging behaviour at run time.
`default_nettype none
module scs_strap_config_select
    import scs_pkg::*;
(
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    por_n_i,
    input  wire scs_pkg::scs_straps_t    strap_pins_i,
    input  wire scs_pkg::scs_straps_t    strap_func_i,
    input  wire logic                    sda_i,
    input  wire logic                    local_power_detect_i,
    input  wire logic [2:0]              reg_fixed_ports_i,
    input  wire logic                    suspend_i,
    input  wire logic                    smbus_wr_i,
    input  wire logic [7:0]              smbus_addr_i,
    input  wire logic                    vendor_msg_disable_i,
    input  wire logic                    hub_attached_i,
    output logic                         strap_oe_o,
    output scs_pkg::scs_straps_t         strap_out_o,
    output scs_pkg::scs_straps_t         captured_o,
    output scs_pkg::scs_method_t         method_o,
    output logic                         invalid_sel_o,
    output logic                         use_straps_o,
    output logic                         self_powered_o,
    output logic                         config_done_o,
    output logic [2:0]                   fixed_ports_o,
    output logic                         suspend_indicator_o,
    output logic [3:0]                   charge_support_o,
    output logic [3:0]                   port_disable_o,
    output scs_pkg::scs_access_t         access_o,
    output logic [1:0]                   smbus_otp_modes_o,
    output logic                         usb_otp_single_only_o
);
    import scs_pkg::*;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_SELECT,
        ST_WAIT_HOST,
        ST_DONE
    } scs_state_t;

    scs_state_t  state_ff;
    scs_straps_t cap_ff;
    logic        sda_cap_ff;
    logic        rst_n;
    scs_method_t nxt_method;

    assign rst_n = reset_n_i & por_n_i;

    function automatic logic [2:0] fix_mask(input logic [1:0] code);
        logic [2:0] m;
        m = FIXMASK_NONE;
        case (code)
            FIX_NONE: m = FIXMASK_NONE;
            FIX_P1:   m = FIXMASK_P1;
            FIX_P12:  m = FIXMASK_P12;
            default:  m = FIXMASK_P123;
        endcase
        return m;
    endfunction

    function automatic scs_method_t pick_method(input logic sda, input logic [1:0] sel);
        scs_method_t m;
        m = MTH_INVALID;
        if (sel == SEL_SELF_PWR) begin
            m = MTH_SELF_PWR;
        end else if (sel == SEL_BUS_PWR) begin
            m = MTH_BUS_PWR;
        end else if (sel == SEL_EEPROM) begin
            // Data low with select 11 is undefined; treated as invalid.
            m = sda ? MTH_EEPROM : MTH_INVALID;
        end else begin
            m = sda ? MTH_SMBUS_HOST : MTH_INVALID;
        end
        return m;
    endfunction

    // The pins float under reset so board resistors set the level being caught.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_oe_o  <= 1'b0; // RL1
            strap_out_o <= '0;
        end else begin
            strap_oe_o  <= 1'b1; // RL1
            strap_out_o <= strap_func_i;
        end
    end

    // Capture happens on the first edge after release, while pins still float.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= ST_RESET;
            cap_ff     <= '0;
            sda_cap_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_RESET: begin
                    cap_ff     <= strap_pins_i; // RL2 RL3
                    sda_cap_ff <= sda_i; // RL4
                    state_ff   <= ST_SELECT;
                end
                ST_SELECT: begin
                    if (nxt_method == MTH_SMBUS_HOST) begin
                        state_ff <= ST_WAIT_HOST; // RL8
                    end else if (nxt_method != MTH_INVALID) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_WAIT_HOST: begin
                    if (smbus_wr_i && smbus_addr_i == CFG_DONE_ADDR) begin
                        state_ff <= ST_DONE; // RL10
                    end
                end
                default: state_ff <= ST_DONE;
            endcase
        end
    end

    assign nxt_method = pick_method(sda_cap_ff, cap_ff.method_select); // RL4

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            method_o       <= MTH_NONE;
            invalid_sel_o  <= 1'b0;
            use_straps_o   <= 1'b0;
            self_powered_o <= 1'b0;
            config_done_o  <= 1'b0;
        end else if (state_ff != ST_RESET) begin
            method_o       <= nxt_method;
            invalid_sel_o  <= (nxt_method == MTH_INVALID); // RL9
            use_straps_o   <= (nxt_method == MTH_SELF_PWR) || (nxt_method == MTH_BUS_PWR); // RL7
            self_powered_o <= (nxt_method == MTH_SELF_PWR); // RL5 RL6
            config_done_o  <= (state_ff == ST_DONE); // RL9
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            fixed_ports_o       <= FIXMASK_NONE;
            captured_o          <= '0;
            suspend_indicator_o <= 1'b0;
            charge_support_o    <= '0;
            port_disable_o      <= '0;
        end else if (state_ff != ST_RESET) begin
            if (local_power_detect_i) begin
                fixed_ports_o <= reg_fixed_ports_i; // RL13
            end else begin
                fixed_ports_o <= fix_mask(cap_ff.fixed_port_straps); // RL11
            end
            // Low bit of the code sets the LED polarity.
            suspend_indicator_o <= suspend_i ^ cap_ff.fixed_port_straps[0]; // RL12
            charge_support_o    <= cap_ff.charge_enable_straps; // RL14
            captured_o          <= cap_ff; // RL2
            port_disable_o      <= cap_ff.port_minus_line_disable
                                   & cap_ff.port_plus_line_disable; // RL15
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            access_o              <= '0;
            smbus_otp_modes_o     <= 2'h0;
            usb_otp_single_only_o <= 1'b0;
        end else begin
            access_o.vendor_msg_enable      <= ~vendor_msg_disable_i; // RL16
            access_o.i2c_passthru_enable    <= 1'b1; // RL17
            access_o.usb_otp_enable         <= 1'b1; // RL18
            access_o.smbus_otp_enable       <= 1'b1; // RL19
            access_o.smbus_cfg_write_enable <= ~hub_attached_i; // RL20
            access_o.usb_charge_ctrl_enable <= 1'b1; // RL21
            smbus_otp_modes_o               <= 2'h3; // RL19
            usb_otp_single_only_o           <= 1'b1; // RL18
        end
    end

    property p_oe_reset;
        @(posedge mclk_i) disable iff (!rst_n) $rose(state_ff == ST_SELECT) |-> strap_oe_o;
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("Strap pins not driven."); // RL1

    property p_capture;
        @(posedge mclk_i) disable iff (!rst_n)
            state_ff == ST_RESET |=> cap_ff == $past(strap_pins_i);
    endproperty
    a_capture: assert property (p_capture) else $error("Strap capture wrong."); // RL2

    property p_invalid;
        @(posedge mclk_i) disable iff (!rst_n)
            (state_ff == ST_SELECT && nxt_method == MTH_INVALID) |=>
            invalid_sel_o && !config_done_o && state_ff == ST_SELECT;
    endproperty
    a_invalid: assert property (p_invalid) else $error("Invalid select proceeded."); // RL9

    property p_host_wait;
        @(posedge mclk_i) disable iff (!rst_n)
            (state_ff == ST_WAIT_HOST && !(smbus_wr_i && smbus_addr_i == CFG_DONE_ADDR))
            |=> state_ff == ST_WAIT_HOST;
    endproperty
    a_host_wait: assert property (p_host_wait) else $error("Host wait left early."); // RL8

    property p_host_done;
        @(posedge mclk_i) disable iff (!rst_n)
            (state_ff == ST_WAIT_HOST && smbus_wr_i && smbus_addr_i == CFG_DONE_ADDR)
            |=> ##1 config_done_o;
    endproperty
    a_host_done: assert property (p_host_done) else $error("Done write not seen."); // RL10

    property p_eeprom;
        @(posedge mclk_i) disable iff (!rst_n)
            (method_o == MTH_EEPROM) |-> !use_straps_o;
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("Straps used in EEPROM mode."); // RL7

    property p_self;
        @(posedge mclk_i) disable iff (!rst_n)
            (state_ff == ST_SELECT && cap_ff.method_select == SEL_SELF_PWR)
            |=> self_powered_o && use_straps_o;
    endproperty
    a_self: assert property (p_self) else $error("Self powered not chosen."); // RL5

    property p_bus;
        @(posedge mclk_i) disable iff (!rst_n)
            (state_ff == ST_SELECT && cap_ff.method_select == SEL_BUS_PWR)
            |=> !self_powered_o && use_straps_o;
    endproperty
    a_bus: assert property (p_bus) else $error("Bus powered not chosen."); // RL6

    property p_disable;
        @(posedge mclk_i) disable iff (!rst_n)
            state_ff == ST_DONE |=> port_disable_o ==
            (cap_ff.port_minus_line_disable & cap_ff.port_plus_line_disable);
    endproperty
    a_disable: assert property (p_disable) else $error("Port disable wrong."); // RL15

    property p_susp;
        @(posedge mclk_i) disable iff (!rst_n)
            state_ff == ST_DONE |=> suspend_indicator_o ==
            ($past(suspend_i) ^ cap_ff.fixed_port_straps[0]);
    endproperty
    a_susp: assert property (p_susp) else $error("Suspend polarity wrong."); // RL12

    // Written bit by bit so that a slip in the mask table is caught.
    property p_fixed;
        @(posedge mclk_i) disable iff (!rst_n)
            (state_ff != ST_RESET && !local_power_detect_i) |=> fixed_ports_o ==
            {cap_ff.fixed_port_straps == FIX_P123, cap_ff.fixed_port_straps[1],
             cap_ff.fixed_port_straps != FIX_NONE};
    endproperty
    a_fixed: assert property (p_fixed) else $error("Fixed port mask wrong."); // RL11

    property p_local;
        @(posedge mclk_i) disable iff (!rst_n)
            (state_ff != ST_RESET && local_power_detect_i) |=>
            fixed_ports_o == $past(reg_fixed_ports_i);
    endproperty
    a_local: assert property (p_local) else $error("Register port mask unused."); // RL13

    property p_charge;
        @(posedge mclk_i) disable iff (!rst_n)
            state_ff != ST_RESET |=> charge_support_o == cap_ff.charge_enable_straps;
    endproperty
    a_charge: assert property (p_charge) else $error("Charge support wrong."); // RL14

    property p_vendor;
        @(posedge mclk_i) disable iff (!rst_n)
            state_ff != ST_RESET |->
            access_o.vendor_msg_enable == !$past(vendor_msg_disable_i);
    endproperty
    a_vendor: assert property (p_vendor) else $error("Vendor message gate wrong."); // RL16

    property p_cfg_write;
        @(posedge mclk_i) disable iff (!rst_n)
            state_ff != ST_RESET |->
            access_o.smbus_cfg_write_enable == !$past(hub_attached_i);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("Config write gate wrong."); // RL20

    c_eeprom: cover property (@(posedge mclk_i) disable iff (!rst_n) method_o == MTH_EEPROM);
    c_host: cover property (@(posedge mclk_i) disable iff (!rst_n)
        state_ff == ST_WAIT_HOST ##1 state_ff == ST_DONE);
    c_invalid: cover property (@(posedge mclk_i) disable iff (!rst_n) invalid_sel_o);
    c_local: cover property (@(posedge mclk_i) disable iff (!rst_n)
        local_power_detect_i && config_done_o);
endmodule : scs_strap_config_select
`default_nettype wire

// ===== scs_pkg.sv
// Purpose: Shared constants and carrier types for the strap configuration selector.
// Assumes: One clock at 100 MHz, straps captured at reset release.
// Notes:   Bit positions and codes are named here once and used by name.
`default_nettype none
package scs_pkg;
    localparam int          NUM_DS_PORTS   = 4;
    localparam int          NUM_FIX_PORTS  = 3;
    localparam logic [1:0]  SEL_SELF_PWR   = 2'h0;
    localparam logic [1:0]  SEL_SMBUS_HOST = 2'h1;
    localparam logic [1:0]  SEL_BUS_PWR    = 2'h2;
    localparam logic [1:0]  SEL_EEPROM     = 2'h3;
    localparam logic [1:0]  FIX_NONE       = 2'h0;
    localparam logic [1:0]  FIX_P1         = 2'h1;
    localparam logic [1:0]  FIX_P12        = 2'h2;
    localparam logic [1:0]  FIX_P123       = 2'h3;
    localparam logic [2:0]  FIXMASK_NONE   = 3'h0;
    localparam logic [2:0]  FIXMASK_P1     = 3'h1;
    localparam logic [2:0]  FIXMASK_P12    = 3'h3;
    localparam logic [2:0]  FIXMASK_P123   = 3'h7;
    localparam logic [7:0]  CFG_DONE_ADDR  = 8'hff;
    localparam int          STRAP_W        = 2 + 2 + 4 + 4 + 4;

    typedef struct packed {
        logic [1:0] method_select;
        logic [1:0] fixed_port_straps;
        logic [3:0] charge_enable_straps;
        logic [3:0] port_minus_line_disable;
        logic [3:0] port_plus_line_disable;
    } scs_straps_t;

    typedef enum logic [2:0] {
        MTH_NONE,
        MTH_SELF_PWR,
        MTH_BUS_PWR,
        MTH_EEPROM,
        MTH_SMBUS_HOST,
        MTH_INVALID
    } scs_method_t;

    typedef struct packed {
        logic vendor_msg_enable;
        logic i2c_passthru_enable;
        logic usb_otp_enable;
        logic smbus_otp_enable;
        logic smbus_cfg_write_enable;
        logic usb_charge_ctrl_enable;
    } scs_access_t;
endpackage : scs_pkg
`default_nettype wire

// ===== scs_board_model.sv
// Purpose: Board side of the strap selector: strap resistors, data line bias, SMBus host.
// Assumes: Resistor levels come from the bench; the host writes one register at a time.
// Notes:   Pins show the resistor level only while the device has released them.
`default_nettype none
module scs_board_model
    import scs_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 strap_oe_i,
    input  wire scs_pkg::scs_straps_t strap_drive_i,
    input  wire scs_pkg::scs_straps_t pull_i,
    input  wire logic                 sda_pull_i,
    output scs_pkg::scs_straps_t      strap_pins_o,
    output logic                      sda_o,
    output logic                      smbus_wr_o,
    output logic [7:0]                smbus_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Resistors only, so the board never fights the device's own drivers.
    assign strap_pins_o = strap_oe_i ? strap_drive_i : pull_i;
    assign sda_o        = sda_pull_i;
    initial begin
        smbus_wr_o   = 1'b0;
        smbus_addr_o = 8'h00;
    end
    // The address is scrambled once the strobe drops, so a stale value cannot pass.
    task automatic host_write(input logic [7:0] addr);
        @(posedge mclk_i);
        #1;
        smbus_wr_o   = 1'b1;
        smbus_addr_o = addr;
        @(posedge mclk_i);
        #1;
        smbus_wr_o   = 1'b0;
        smbus_addr_o = ~addr;
    endtask
endmodule // scs_board_model
`default_nettype wire

// ===== tb_scs_strap_config_select.sv
// Purpose: Self-checking bench for the strap configuration selector.
// Assumes: Method outputs settle two edges after reset release, done one edge later.
// Notes:   Every select code and fixed-port code is visited in one run.
`default_nettype none
module tb_scs_strap_config_select;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;
    logic        mclk, reset_n, por_n, sda, sda_pull, lpd, suspend, vmd, attached, wr;
    logic        oe, inv, use_s, self_p, done, sus_ind, single_only, exp_done;
    logic [2:0]  reg_fixed, fixed;
    logic [7:0]  addr;
    logic [1:0]  otp_modes;
    logic [3:0]  chg, dis;
    scs_straps_t pins, func, pull, sout, cap;
    scs_method_t method;
    scs_access_t acc;
    int          fails, samples_checked;
    logic [6:0]  sda_tab = 7'h1a;
    logic [1:0]  sel_tab [7] = '{SEL_SELF_PWR, SEL_SELF_PWR, SEL_BUS_PWR, SEL_EEPROM,
                                SEL_SMBUS_HOST, SEL_SMBUS_HOST, SEL_EEPROM};
    scs_method_t meth_tab [7] = '{MTH_SELF_PWR, MTH_SELF_PWR, MTH_BUS_PWR, MTH_EEPROM,
                                 MTH_SMBUS_HOST, MTH_INVALID, MTH_INVALID};
    logic [2:0]  mask_tab [4] = '{FIXMASK_NONE, FIXMASK_P1, FIXMASK_P12, FIXMASK_P123};

    scs_strap_config_select scs_strap_config_select_i (
        .mclk_i(mclk), .reset_n_i(reset_n), .por_n_i(por_n), .strap_pins_i(pins),
        .strap_func_i(func), .sda_i(sda), .local_power_detect_i(lpd),
        .reg_fixed_ports_i(reg_fixed), .suspend_i(suspend), .smbus_wr_i(wr),
        .smbus_addr_i(addr), .vendor_msg_disable_i(vmd), .hub_attached_i(attached),
        .strap_oe_o(oe), .strap_out_o(sout), .captured_o(cap), .method_o(method),
        .invalid_sel_o(inv), .use_straps_o(use_s), .self_powered_o(self_p),
        .config_done_o(done), .fixed_ports_o(fixed), .suspend_indicator_o(sus_ind),
        .charge_support_o(chg), .port_disable_o(dis), .access_o(acc),
        .smbus_otp_modes_o(otp_modes), .usb_otp_single_only_o(single_only));

    scs_board_model scs_board_model_i (
        .mclk_i(mclk), .strap_oe_i(oe), .strap_drive_i(sout), .pull_i(pull),
        .sda_pull_i(sda_pull), .strap_pins_o(pins), .sda_o(sda), .smbus_wr_o(wr),
        .smbus_addr_o(addr));

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Either reset source alone must release the pins and force a fresh capture.
    task automatic do_reset(input logic by_por);
        if (by_por) por_n = 1'b0;
        else reset_n = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        chk("oe_in_reset", 16'h0, oe);
        chk("out_in_reset", 16'h0, sout);
        por_n   = 1'b1;
        reset_n = 1'b1;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #20000;
        fails++;
        $display("BAD watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        {reset_n, por_n, sda_pull, lpd, suspend, vmd, attached} = '0;
        {pull, func} = '0;
        reg_fixed = 3'h5;
        fails = 0;
        samples_checked = 0;
        for (int i = 0; i < 7; i++) begin
            pull = {sel_tab[i], i[1:0], 4'h1 << i[1:0], 4'hc, 4'h5 ^ i[3:0]};
            func = ~pull;
            sda_pull = sda_tab[i];
            lpd = (i == 3);
            vmd = i[0];
            attached = i[1];
            suspend = 1'b1;
            do_reset(i[0]);
            step(2);
            chk("method", meth_tab[i], method);
            chk("captured", pull, cap);
            chk("invalid", meth_tab[i] == MTH_INVALID, inv);
            chk("use_straps", sel_tab[i] inside {SEL_SELF_PWR, SEL_BUS_PWR}, use_s);
            chk("self_powered", meth_tab[i] == MTH_SELF_PWR, self_p);
            chk("done_early", 16'h0, done);
            chk("fixed", lpd ? reg_fixed : mask_tab[i[1:0]], fixed);
            chk("suspend_indicator", !i[0], sus_ind);
            chk("charge", pull.charge_enable_straps, chg);
            chk("dis", pull.port_minus_line_disable & pull.port_plus_line_disable, dis);
            chk("strap_oe", 16'h1, oe);
            chk("strap_out", func, sout);
            chk("vendor_msg", !vmd, acc.vendor_msg_enable);
            chk("smbus_cfg_wr", !attached, acc.smbus_cfg_write_enable);
            chk("otp_modes", 16'h3, otp_modes);
            chk("otp_single", 16'h1, single_only);
            chk("access", {!vmd, 3'h7, !attached, 1'b1}, acc);
            exp_done = meth_tab[i] inside {MTH_SELF_PWR, MTH_BUS_PWR, MTH_EEPROM};
            suspend = 1'b0;
            step(1);
            chk("done", exp_done, done);
            step(1);
            chk("suspend_indicator_idle", i[0], sus_ind);
            if (meth_tab[i] inside {MTH_SMBUS_HOST, MTH_INVALID}) begin
                scs_board_model_i.host_write(8'hfe);
                step(3);
                chk("done_wrong_addr", 16'h0, done);
                scs_board_model_i.host_write(CFG_DONE_ADDR);
                step(3);
                chk("done_host", meth_tab[i] == MTH_SMBUS_HOST, done);
            end
        end
        end_of_test();
    end
endmodule // tb_scs_strap_config_select
`default_nettype wire
